// ### hw/ea_core_consts.vh
`ifndef EA_CORE_CONSTS_VH
`define EA_CORE_CONSTS_VH

// Addressing mode codes on the mode select input.
`define MODE_DATA_DIRECT  4'h0
`define MODE_ADDR_DIRECT  4'h1
`define MODE_INDIRECT     4'h2
`define MODE_POST_INC     4'h3
`define MODE_PRE_DEC      4'h4
`define MODE_IND_DISP     4'h5
`define MODE_IND_INDEX    4'h6
`define MODE_ABS_SHORT    4'h7
`define MODE_ABS_LONG     4'h8
`define MODE_PC_DISP      4'h9
`define MODE_PC_INDEX     4'hA
`define MODE_IMMEDIATE    4'hB
`define MODE_QUICK        4'hC
`define MODE_IMPLIED      4'hD

// Operand sizes.
`define SIZE_BYTE         2'h0
`define SIZE_WORD         2'h1
`define SIZE_LONG         2'h2

// Address register step sizes.
`define STEP_BYTE         32'h0000_0001
`define STEP_WORD         32'h0000_0002
`define STEP_LONG         32'h0000_0004
`define STEP_SP_BYTE      32'h0000_0002
`define SP_INDEX          3'h7

// Implied register selects.
`define IMPL_STATUS       2'h0
`define IMPL_USP          2'h1
`define IMPL_SSP          2'h2
`define IMPL_PC           2'h3

// Operation codes.
`define OP_DEC_ADD        5'h00
`define OP_DEC_SUB        5'h01
`define OP_DEC_NEG        5'h02
`define OP_ASL            5'h03
`define OP_ASR            5'h04
`define OP_LSL            5'h05
`define OP_LSR            5'h06
`define OP_ROL            5'h07
`define OP_ROR            5'h08
`define OP_ROTATE_LEFT_X           5'h09
`define OP_ROTATE_RIGHT_X           5'h0A
`define OP_MUL_U          5'h0B
`define OP_MUL_S          5'h0C
`define OP_DIV_U          5'h0D
`define OP_DIV_S          5'h0E
`define OP_BIT_TEST       5'h0F
`define OP_BIT_INVERT     5'h10
`define OP_BIT_CLEAR      5'h11
`define OP_BIT_SET        5'h12
`define OP_TEST_SET       5'h13
`define OP_TRAP           5'h14
`define OP_TRAP_OVF       5'h15

// Status word field positions and reset value.
`define SR_C              0
`define SR_V              1
`define SR_Z              2
`define SR_N              3
`define SR_X              4
`define SR_S              13
`define SR_RESET          16'h2700

// Trap vectors; plain defaults.
`define VEC_ZERO_DIV      8'h05
`define VEC_OVERFLOW      8'h07
`define VEC_TRAP_BASE     8'h20

// Divider iterations for a 32 by 16 bit divide.
`define DIV_STEPS         6'h20

`endif

// ### hw/decimal_shift_unit.v
`timescale 1ns/1ns
`include "ea_core_consts.vh"

module decimal_shift_unit (
  // Operation
  input  wire [4:0]  op,
  input  wire [1:0]  size,
  input  wire [5:0]  count,
  // Operands and incoming flags
  input  wire [31:0] src,
  input  wire [31:0] dst,
  input  wire        x_in,
  input  wire        z_in,
  // Result
  output reg  [31:0] result,
  output reg  [4:0]  flags
);

  reg [31:0] v;
  reg [31:0] mask;
  reg [4:0]  w;
  reg [8:0]  t;
  reg        c;
  reg        x;
  reg        ov;
  reg        m;
  reg [5:0]  lo;
  integer    i;

  always @* begin
    v      = dst;
    c      = 1'b0;
    x      = x_in;
    ov     = 1'b0;
    t      = 9'h000;
    lo     = 6'h00;
    m      = 1'b0;
    w      = (size == `SIZE_BYTE) ? 5'd7 : (size == `SIZE_WORD) ? 5'd15 : 5'd31;
    mask   = (size == `SIZE_BYTE) ? 32'h0000_00FF :
             (size == `SIZE_WORD) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    result = 32'h0000_0000;
    flags  = 5'h00;
    if (op <= `OP_DEC_NEG) begin
      // Decimal work is byte wide; the nibble carries use the extend flag.
      if (op == `OP_DEC_ADD) begin
        lo = {2'b00, dst[3:0]} + {2'b00, src[3:0]} + {5'h00, x_in};
        t  = {1'b0, dst[7:0]} + {1'b0, src[7:0]} + {8'h00, x_in};
        if (lo > 6'd9)
          t = t + 9'h006;
        if (t > 9'h099)
          t = t + 9'h060;
        c = (t > 9'h099) | t[8];
      end else begin
        m  = (op == `OP_DEC_NEG);
        lo = {2'b00, (m ? 4'h0 : dst[3:0])} - {2'b00, src[3:0]}
             - {5'h00, x_in};
        t  = {1'b0, (m ? 8'h00 : dst[7:0])} - {1'b0, src[7:0]}
             - {8'h00, x_in};
        c  = t[8];
        if (lo[5])
          t = t - 9'h006;
        if (c)
          t = t - 9'h060;
      end
      result = {dst[31:8], t[7:0]};
      flags  = {c, t[7], z_in & (t[7:0] == 8'h00), 1'b0, c};
    end else begin
      // Bit-serial model: each pass moves one place, up to the count.
      v = dst & mask;
      if (op == `OP_ROTATE_LEFT_X || op == `OP_ROTATE_RIGHT_X)
        c = x_in;
      for (i = 0; i < 64; i = i + 1) begin
        if (i < count) begin
          case (op)
            `OP_ASL, `OP_LSL, `OP_ROL, `OP_ROTATE_LEFT_X: begin
              c = v[w];
              v = (v << 1) & mask;
              if (op == `OP_ASL && (v[w] != c))
                ov = 1'b1;
              if (op == `OP_ROL)
                v[0] = c;
              if (op == `OP_ROTATE_LEFT_X) begin
                v[0] = x;
                x    = c;
              end else if (op != `OP_ROL) begin
                x = c;
              end
            end
            default: begin
              c = v[0];
              m = (op == `OP_ASR) ? v[w] : (op == `OP_ROR) ? c :
                  (op == `OP_ROTATE_RIGHT_X) ? x : 1'b0;
              v    = v >> 1;
              v[w] = m;
              if (op != `OP_ROR)
                x = c;
            end
          endcase
        end
      end
      result = (dst & ~mask) | v;
      flags  = {x, v[w], (v == 32'h0000_0000), ov, c};
    end
  end

endmodule // decimal_shift_unit

// ### hw/mul_div_unit.v
`timescale 1ns/1ns
`include "ea_core_consts.vh"

module mul_div_unit (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        reset_n,
  // Request
  input  wire        start,
  input  wire        is_signed,
  input  wire        is_div,
  input  wire [31:0] dst,
  input  wire [15:0] src,
  // Answer
  output reg         done_q,
  output reg  [31:0] result_q,
  output reg         ovf_q,
  output reg         zero_div_q
);

  reg  [31:0] quo_q;
  reg  [16:0] rem_q;
  reg  [5:0]  cnt_q;
  reg         busy_q;
  reg         neg_q_q;
  reg         neg_r_q;
  reg         sgn_q;
  wire [31:0] a_abs = (is_signed & dst[31]) ? (~dst + 32'h0000_0001) : dst;
  wire [15:0] b_abs = (is_signed & src[15]) ? (~src + 16'h0001) : src;
  reg  [15:0] div_q;
  wire [16:0] trial = {rem_q[15:0], quo_q[31]};
  wire [31:0] q_fin = neg_q_q ? (~quo_q + 32'h0000_0001) : quo_q;
  wire [15:0] r_fin = neg_r_q ? (~rem_q[15:0] + 16'h0001) : rem_q[15:0];
  wire        fits  = sgn_q ? (q_fin[31:15] == {17{q_fin[15]}}) :
                      (quo_q[31:16] == 16'h0000);

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      done_q     <= 1'b0;
      result_q   <= 32'h0000_0000;
      ovf_q      <= 1'b0;
      zero_div_q <= 1'b0;
      quo_q      <= 32'h0000_0000;
      rem_q      <= 17'h0_0000;
      cnt_q      <= 6'h00;
      busy_q     <= 1'b0;
      neg_q_q    <= 1'b0;
      neg_r_q    <= 1'b0;
      sgn_q      <= 1'b0;
      div_q      <= 16'h0000;
    end else begin
      done_q     <= 1'b0;
      zero_div_q <= 1'b0;
      if (start && !is_div) begin
        if (is_signed)
          result_q <= $signed(dst[15:0]) * $signed(src);
        else
          result_q <= dst[15:0] * src;
        ovf_q    <= 1'b0;
        done_q   <= 1'b1;
      end else if (start && src == 16'h0000) begin
        zero_div_q <= 1'b1;
        done_q     <= 1'b1;
        ovf_q      <= 1'b0;
        result_q   <= dst;
      end else if (start) begin
        quo_q   <= a_abs;
        div_q   <= b_abs;
        rem_q   <= 17'h0_0000;
        cnt_q   <= `DIV_STEPS;
        busy_q  <= 1'b1;
        neg_q_q <= is_signed & (dst[31] ^ src[15]);
        neg_r_q <= is_signed & dst[31];
        sgn_q   <= is_signed;
      end else if (busy_q && cnt_q != 6'h00) begin
        // Restoring division, one quotient bit per clock.
        cnt_q <= cnt_q - 6'h01;
        if (trial >= {1'b0, div_q}) begin
          rem_q <= trial - {1'b0, div_q};
          quo_q <= {quo_q[30:0], 1'b1};
        end else begin
          rem_q <= trial;
          quo_q <= {quo_q[30:0], 1'b0};
        end
      end else if (busy_q) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
        // Overflow keeps the destination untouched.
        ovf_q  <= !fits;
        if (fits)
          result_q <= {r_fin, q_fin[15:0]};
        else
          result_q <= dst;
      end
    end
  end

endmodule // mul_div_unit

// ### hw/effective_address_generation.v
// What this block does
// - Handles bit, decimal, byte, word, long operands
// - Fourteen addressing modes across six families
// - Direct modes return the chosen register itself
// - Absolute addresses from one or two extensions
// - Counter plus displacement, optionally plus index
// - Indirect uses register; postincrement steps after
// - Predecrement steps first, then uses register
// - Register plus displacement, or index plus displacement
// - Step is one, two or four bytes
// - Stack pointer byte step is two
// - Immediate from extensions; quick from opcode field
// - Implied picks status, stack pointers or counter
// - Index may be data or address register
// - Decimal add, subtract, negate use extend flag
// - Rotates with and without extend, plus shifts
// - Signed and unsigned multiply and divide
// - Bit test, then keep, invert, clear, set
// - Test-and-set, software trap, overflow trap
`timescale 1ns/1ns
`include "ea_core_consts.vh"

module effective_address_generation (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        reset_n,
  // Operand address request
  input  wire        ea_req,
  input  wire [3:0]  ea_mode,
  input  wire [1:0]  ea_size,
  input  wire [2:0]  addr_reg_sel,
  input  wire [2:0]  data_reg_sel,
  input  wire [3:0]  index_reg_sel,
  input  wire        index_long,
  input  wire [1:0]  implied_sel,
  input  wire [15:0] ext_word0,
  input  wire [15:0] ext_word1,
  input  wire [15:0] opcode_word,
  input  wire [31:0] pc_in,
  // Operand address answer
  output reg         ea_done_q,
  output reg  [31:0] operand_address_q,
  output reg  [31:0] operand_value_q,
  output reg         operand_is_mem_q,
  // Register write port
  input  wire        reg_wr_en,
  input  wire [3:0]  reg_wr_sel,
  input  wire [31:0] reg_wr_data,
  input  wire        status_wr_en,
  input  wire [15:0] status_wr_data,
  // Operation request
  input  wire        op_req,
  input  wire [4:0]  op_code,
  input  wire [1:0]  op_size,
  input  wire        op_mem_dst,
  input  wire [5:0]  op_count,
  input  wire [31:0] op_src,
  input  wire [31:0] op_dst,
  // Operation answer
  output wire        op_ready,
  output reg         op_done_q,
  output reg  [31:0] op_result_q,
  output reg         trap_req_q,
  output reg  [7:0]  trap_vector_q,
  // Architectural state
  output reg  [15:0] status_word,
  output reg  [31:0] user_stack_ptr,
  output reg  [31:0] super_stack_ptr
);

  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;

  reg  [31:0] data_q [0:7];
  reg  [31:0] addr_q [0:6];
  reg         state_q;
  reg         state_d;
  reg  [31:0] ea_addr;
  reg  [31:0] ea_value;
  reg         ea_mem;
  reg         ea_step_en;
  reg  [31:0] ea_step_val;
  reg  [31:0] ea_base;
  reg  [31:0] ea_index;
  reg  [31:0] step;
  reg  [31:0] exec_result;
  reg  [4:0]  exec_flags;
  reg         exec_trap;
  reg  [7:0]  exec_vector;
  reg  [4:0]  bitno;
  reg  [7:0]  tas_byte;
  reg  [4:0]  flags_q;
  reg         flags_wr_q;
  reg  [4:0]  fmask_q;
  integer     i;

  wire [31:0] ds_result;
  wire [4:0]  ds_flags;
  wire        md_done;
  wire [31:0] md_result;
  wire        md_ovf;
  wire        md_zero;
  wire        is_md = (op_code >= `OP_MUL_U) && (op_code <= `OP_DIV_S);
  wire        md_start = op_req && (state_q == ST_IDLE) && is_md;
  wire        op_take = op_req && (state_q == ST_IDLE) && !is_md;

  function [31:0] sext16;
    input [15:0] v;
    begin
      sext16 = {{16{v[15]}}, v};
    end
  endfunction

  function [31:0] sext8;
    input [7:0] v;
    begin
      sext8 = {{24{v[7]}}, v};
    end
  endfunction

  // Address register read; register seven follows the privilege bit.
  function [31:0] areg;
    input [2:0] sel;
    begin
      if (sel != `SP_INDEX)
        areg = addr_q[sel];
      else if (status_word[`SR_S])
        areg = super_stack_ptr;
      else
        areg = user_stack_ptr;
    end
  endfunction

  function [31:0] step_of;
    input [1:0] size;
    input [2:0] sel;
    begin
      case (size)
        `SIZE_BYTE: step_of = (sel == `SP_INDEX) ? `STEP_SP_BYTE :
                              `STEP_BYTE;
        `SIZE_WORD: step_of = `STEP_WORD;
        default:    step_of = `STEP_LONG;
      endcase
    end
  endfunction

  decimal_shift_unit u_decimal_shift (
    .op     (op_code),
    .size   (op_size),
    .count  (op_count),
    .src    (op_src),
    .dst    (op_dst),
    .x_in   (status_word[`SR_X]),
    .z_in   (status_word[`SR_Z]),
    .result (ds_result),
    .flags  (ds_flags)
  );

  mul_div_unit u_mul_div (
    .clk_sys    (clk_sys),
    .reset_n    (reset_n),
    .start      (md_start),
    .is_signed  ((op_code == `OP_MUL_S) || (op_code == `OP_DIV_S)),
    .is_div     (op_code >= `OP_DIV_U),
    .dst        (op_dst),
    .src        (op_src[15:0]),
    .done_q     (md_done),
    .result_q   (md_result),
    .ovf_q      (md_ovf),
    .zero_div_q (md_zero)
  );

  assign op_ready = (state_q == ST_IDLE);

  // Operand address formation.
  always @* begin
    ea_base     = areg(addr_reg_sel);
    step        = step_of(ea_size, addr_reg_sel);
    ea_index    = index_reg_sel[3] ? areg(index_reg_sel[2:0]) :
                  data_q[index_reg_sel[2:0]];
    if (!index_long)
      ea_index  = sext16(ea_index[15:0]);
    ea_addr     = 32'h0000_0000;
    ea_value    = 32'h0000_0000;
    ea_mem      = 1'b1;
    ea_step_en  = 1'b0;
    ea_step_val = ea_base;
    case (ea_mode)
      `MODE_DATA_DIRECT: begin
        ea_value = data_q[data_reg_sel];
        ea_mem   = 1'b0;
      end
      `MODE_ADDR_DIRECT: begin
        ea_value = ea_base;
        ea_mem   = 1'b0;
      end
      `MODE_INDIRECT:
        ea_addr = ea_base;
      `MODE_POST_INC: begin
        ea_addr     = ea_base;
        ea_step_en  = 1'b1;
        ea_step_val = ea_base + step;
      end
      `MODE_PRE_DEC: begin
        ea_step_en  = 1'b1;
        ea_step_val = ea_base - step;
        ea_addr     = ea_step_val;
      end
      `MODE_IND_DISP:
        ea_addr = ea_base + sext16(ext_word0);
      `MODE_IND_INDEX:
        ea_addr = ea_base + ea_index + sext8(ext_word0[7:0]);
      `MODE_ABS_SHORT:
        ea_addr = sext16(ext_word0);
      `MODE_ABS_LONG:
        ea_addr = {ext_word0, ext_word1};
      `MODE_PC_DISP:
        ea_addr = pc_in + sext16(ext_word0);
      `MODE_PC_INDEX:
        ea_addr = pc_in + ea_index + sext8(ext_word0[7:0]);
      `MODE_IMMEDIATE: begin
        ea_mem = 1'b0;
        case (ea_size)
          `SIZE_BYTE: ea_value = {24'h00_0000, ext_word0[7:0]};
          `SIZE_WORD: ea_value = {16'h0000, ext_word0};
          default:    ea_value = {ext_word0, ext_word1};
        endcase
      end
      `MODE_QUICK: begin
        ea_mem   = 1'b0;
        // A zero field encodes eight.
        ea_value = (opcode_word[11:9] == 3'h0) ? 32'h0000_0008 :
                   {29'h0000_0000, opcode_word[11:9]};
      end
      `MODE_IMPLIED: begin
        ea_mem = 1'b0;
        case (implied_sel)
          `IMPL_STATUS: ea_value = {16'h0000, status_word};
          `IMPL_USP:    ea_value = user_stack_ptr;
          `IMPL_SSP:    ea_value = super_stack_ptr;
          default:      ea_value = pc_in;
        endcase
      end
      default: begin
        ea_mem = 1'b0;
      end
    endcase
  end

  // Operation datapath for everything the shared units do not cover.
  always @* begin
    exec_result = ds_result;
    exec_flags  = ds_flags;
    exec_trap   = 1'b0;
    exec_vector = 8'h00;
    tas_byte    = op_dst[7:0];
    // Memory bit numbers wrap at eight, register bit numbers at 32.
    bitno = op_mem_dst ? {2'b00, op_src[2:0]} : op_src[4:0];
    case (op_code)
      `OP_BIT_TEST, `OP_BIT_INVERT, `OP_BIT_CLEAR, `OP_BIT_SET: begin
        exec_flags  = {3'b000, ~op_dst[bitno], 1'b0} << 1;
        exec_result = op_dst;
        if (op_code == `OP_BIT_INVERT)
          exec_result[bitno] = ~op_dst[bitno];
        else if (op_code == `OP_BIT_CLEAR)
          exec_result[bitno] = 1'b0;
        else if (op_code == `OP_BIT_SET)
          exec_result[bitno] = 1'b1;
      end
      `OP_TEST_SET: begin
        tas_byte    = op_dst[7:0] | 8'h80;
        exec_result = {op_dst[31:8], tas_byte};
        exec_flags  = {1'b0, op_dst[7], (op_dst[7:0] == 8'h00), 2'b00};
      end
      `OP_TRAP: begin
        exec_result = op_dst;
        exec_trap   = 1'b1;
        exec_vector = `VEC_TRAP_BASE + {4'h0, opcode_word[3:0]};
      end
      `OP_TRAP_OVF: begin
        exec_result = op_dst;
        exec_trap   = status_word[`SR_V];
        exec_vector = `VEC_OVERFLOW;
      end
      default: begin
      end
    endcase
  end

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (md_start) state_d = ST_WAIT;
      ST_WAIT: if (md_done) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always @(posedge clk_sys) begin
    if (!reset_n) begin
      for (i = 0; i < 8; i = i + 1)
        data_q[i] <= 32'h0000_0000;
      for (i = 0; i < 7; i = i + 1)
        addr_q[i] <= 32'h0000_0000;
      user_stack_ptr    <= 32'h0000_0000;
      super_stack_ptr   <= 32'h0000_0000;
      status_word       <= `SR_RESET;
      state_q           <= ST_IDLE;
      ea_done_q         <= 1'b0;
      operand_address_q <= 32'h0000_0000;
      operand_value_q   <= 32'h0000_0000;
      operand_is_mem_q  <= 1'b0;
      op_done_q         <= 1'b0;
      op_result_q       <= 32'h0000_0000;
      trap_req_q        <= 1'b0;
      trap_vector_q     <= 8'h00;
      flags_q           <= 5'h00;
      flags_wr_q        <= 1'b0;
      fmask_q           <= 5'h00;
    end else begin
      state_q    <= state_d;
      ea_done_q  <= ea_req;
      op_done_q  <= op_take | md_done;
      trap_req_q <= op_take & exec_trap;
      flags_wr_q <= op_take | md_done;
      if (ea_req) begin
        operand_address_q <= ea_addr;
        operand_value_q   <= ea_value;
        operand_is_mem_q  <= ea_mem;
      end
      if (op_take) begin
        op_result_q   <= exec_result;
        trap_vector_q <= exec_vector;
        flags_q       <= exec_flags;
        // Bit tests touch only Z; traps touch no flag.
        if (op_code >= `OP_BIT_TEST && op_code <= `OP_BIT_SET)
          fmask_q <= 5'h04;
        else if (op_code >= `OP_TRAP)
          fmask_q <= 5'h00;
        else if (op_code == `OP_TEST_SET || op_code == `OP_ROL ||
                 op_code == `OP_ROR)
          fmask_q <= 5'h0F;
        else
          fmask_q <= 5'h1F;
      end else if (md_done) begin
        op_result_q   <= md_result;
        trap_req_q    <= md_zero;
        trap_vector_q <= `VEC_ZERO_DIV;
        flags_q       <= {1'b0, md_result[15], (md_result[15:0] == 16'h0000),
                          md_ovf, 1'b0};
        fmask_q       <= md_zero ? 5'h00 : 5'h0F;
      end
      // An external status write wins over the flag update.
      if (status_wr_en)
        status_word <= status_wr_data;
      else if (flags_wr_q)
        status_word[4:0] <= (status_word[4:0] & ~fmask_q) |
                            (flags_q & fmask_q);
      // The step lands on every clock edge that sees ea_req high, so a request
      // held for several cycles steps the register once per cycle.
      if (ea_req && ea_step_en) begin
        if (addr_reg_sel != `SP_INDEX)
          addr_q[addr_reg_sel] <= ea_step_val;
        else if (status_word[`SR_S])
          super_stack_ptr <= ea_step_val;
        else
          user_stack_ptr <= ea_step_val;
      end
      // The write port is placed last so it wins a same-register clash.
      if (reg_wr_en) begin
        if (!reg_wr_sel[3])
          data_q[reg_wr_sel[2:0]] <= reg_wr_data;
        else if (reg_wr_sel[2:0] != `SP_INDEX)
          addr_q[reg_wr_sel[2:0]] <= reg_wr_data;
        else if (status_word[`SR_S])
          super_stack_ptr <= reg_wr_data;
        else
          user_stack_ptr <= reg_wr_data;
      end
    end
  end

endmodule // effective_address_generation

// ### sim/eag_props.sv
`timescale 1ns/1ns
`include "ea_core_consts.vh"

module eag_props (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        reset_n,
  // Address request and answer
  input wire logic        ea_req,
  input wire logic [3:0]  ea_mode,
  input wire logic [1:0]  implied_sel,
  input wire logic [15:0] ext_word0,
  input wire logic [15:0] ext_word1,
  input wire logic [15:0] opcode_word,
  input wire logic [31:0] pc_in,
  input wire logic        ea_done_q,
  input wire logic [31:0] operand_address_q,
  input wire logic [31:0] operand_value_q,
  input wire logic        operand_is_mem_q,
  // Operation request and answer
  input wire logic        op_req,
  input wire logic [4:0]  op_code,
  input wire logic [31:0] op_src,
  input wire logic [31:0] op_dst,
  input wire logic        op_ready,
  input wire logic        op_done_q,
  input wire logic [31:0] op_result_q,
  input wire logic        trap_req_q,
  input wire logic [7:0]  trap_vector_q,
  input wire logic [15:0] status_word
);
  // Inputs one cycle back, the product also two back, so each answer is tied to its own request.
  logic [15:0] ext0_q, ext1_q, opc_q;
  logic [31:0] pc_q, mul_q, mul_qq;
  always @(posedge clk_sys) begin
    ext0_q <= ext_word0;
    ext1_q <= ext_word1;
    opc_q  <= opcode_word;
    pc_q   <= pc_in;
    mul_q  <= op_dst[15:0] * op_src[15:0];
    mul_qq <= mul_q;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_ea_answer_due: assert property (ea_req |=> ea_done_q)
    else $error("address answer missing");
  a_quick_data: assert property (
    ea_req && ea_mode == `MODE_QUICK |=>
    operand_value_q == ((opc_q[11:9] == 3'h0) ? 32'h0000_0008
    : {29'h0000_0000, opc_q[11:9]})) else $error("quick data wrong");
  a_abs_long_addr: assert property (
    ea_req && ea_mode == `MODE_ABS_LONG |=>
    operand_is_mem_q && operand_address_q == {ext0_q, ext1_q})
    else $error("absolute long address wrong");
  a_pc_offset: assert property (
    ea_req && ea_mode == `MODE_PC_DISP |=>
    operand_address_q == pc_q + {{16{ext0_q[15]}}, ext0_q})
    else $error("counter relative address wrong");
  a_implied_pc: assert property (
    ea_req && ea_mode == `MODE_IMPLIED &&
    implied_sel == `IMPL_PC |=> operand_value_q == pc_q)
    else $error("implied counter wrong");
  a_trap_vector: assert property (
    op_req && op_ready && op_code == `OP_TRAP
    |=> trap_req_q && trap_vector_q == `VEC_TRAP_BASE + opc_q[3:0])
    else $error("trap vector wrong");
  a_ovf_trap_quiet: assert property (
    op_req && op_ready &&
    op_code == `OP_TRAP_OVF && !status_word[`SR_V] |=> !trap_req_q)
    else $error("overflow trap without overflow");
  a_mul_result: assert property (
    op_req && op_ready && op_code == `OP_MUL_U
    |-> ##2 op_done_q && op_result_q == mul_qq)
    else $error("multiply result wrong");
  a_div_busy: assert property (
    op_req && op_ready && op_code == `OP_DIV_U &&
    op_src[15:0] != 16'h0000 |=> !op_ready [*8])
    else $error("divide not busy");
endmodule // eag_props

bind effective_address_generation eag_props eag_props_inst (.*);

// ### sim/effective_address_generation_tb.sv
`timescale 1ns/1ns
`include "ea_core_consts.vh"

module effective_address_generation_tb;
  reg         clk_sys = 0, reset_n = 0, ea_req = 0, index_long = 0;
  reg         reg_wr_en = 0, op_req = 0;
  reg  [3:0]  ea_mode = 0, index_reg_sel = 0, reg_wr_sel = 0;
  reg  [1:0]  ea_size = 0, implied_sel = 0;
  reg  [2:0]  addr_reg_sel = 0, data_reg_sel = 0;
  reg  [15:0] ext_word0 = 0, ext_word1 = 0, opcode_word = 0;
  reg  [31:0] pc_in = 0, reg_wr_data = 0, op_src = 0, op_dst = 0;
  reg  [4:0]  op_code = 0;
  reg  [5:0]  op_count = 0;
  wire        ea_done_q, operand_is_mem_q, op_ready, op_done_q, trap_req_q;
  wire [31:0] operand_address_q, operand_value_q, op_result_q;
  wire [31:0] user_stack_ptr, super_stack_ptr;
  wire [15:0] status_word;
  wire [7:0]  trap_vector_q;
  int         n_fail = 0, n_checks = 0;

  effective_address_generation effective_address_generation_inst (.*,
    .status_wr_en(1'b0), .status_wr_data(16'h0000), .op_size(2'h0),
    .op_mem_dst(1'b0));

  initial forever #20 clk_sys = ~clk_sys;

  task complete_run;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input [3:0] s, input [31:0] d);
    @(posedge clk_sys);
    reg_wr_en <= 1; reg_wr_sel <= s; reg_wr_data <= d;
    @(posedge clk_sys);
    reg_wr_en <= 0;
  endtask
  // The answer is due exactly one cycle after the request edge.
  task ea(input [3:0] m, input [1:0] s, input [2:0] a, input [15:0] e);
    @(posedge clk_sys);
    ea_req <= 1; ea_mode <= m; ea_size <= s; addr_reg_sel <= a;
    ext_word0 <= e;
    @(posedge clk_sys);
    ea_req <= 0;
    #1 chk(ea_done_q, 1);
  endtask
  task op(input [4:0] c, input [31:0] s, input [31:0] d, input int w);
    @(posedge clk_sys);
    op_req <= 1; op_code <= c; op_src <= s; op_dst <= d;
    @(posedge clk_sys);
    op_req <= 0;
    repeat (w) @(posedge clk_sys);
    #1 chk(op_done_q, 1);
  endtask

  task t_direct;
    wr(4'h3, 32'h1234_5678);
    data_reg_sel <= 3'h3;
    ea(`MODE_DATA_DIRECT, `SIZE_LONG, 3'h0, 16'h0000);
    chk(operand_value_q, 32'h1234_5678);
    wr(4'h9, 32'h0000_4000);
    ea(`MODE_ADDR_DIRECT, `SIZE_LONG, 3'h1, 16'h0000);
    chk(operand_value_q, 32'h0000_4000);
  endtask
  task t_step;
    wr(4'hA, 32'h0000_1000);
    ea(`MODE_POST_INC, `SIZE_WORD, 3'h2, 16'h0000);
    chk(operand_address_q, 32'h0000_1000);
    ea(`MODE_POST_INC, `SIZE_LONG, 3'h2, 16'h0000);
    ea(`MODE_POST_INC, `SIZE_BYTE, 3'h2, 16'h0000);
    chk(operand_address_q, 32'h0000_1006);
    ea(`MODE_INDIRECT, `SIZE_BYTE, 3'h2, 16'h0000);
    chk(operand_address_q, 32'h0000_1007);
    wr(4'hF, 32'h0000_2000);
    ea(`MODE_PRE_DEC, `SIZE_BYTE, 3'h7, 16'h0000);
    chk(operand_address_q, 32'h0000_1FFE);
    chk(super_stack_ptr, 32'h0000_1FFE);
  endtask
  // Negative displacements catch a missing sign extension; the negative index is used as a long.
  task t_index;
    wr(4'h3, 32'hFFFF_FFFC);
    index_reg_sel <= 4'h3; index_long <= 1; pc_in <= 32'h0000_0100;
    ea(`MODE_IND_INDEX, `SIZE_WORD, 3'h1, 16'h00FE);
    chk(operand_address_q, 32'h0000_3FFA);
    index_long <= 0; index_reg_sel <= 4'h9;
    ea(`MODE_PC_INDEX, `SIZE_WORD, 3'h1, 16'h0010);
    chk(operand_address_q, 32'h0000_4110);
    ea(`MODE_IND_DISP, `SIZE_WORD, 3'h1, 16'h8000);
    chk(operand_address_q, 32'hFFFF_C000);
    ea(`MODE_PC_DISP, `SIZE_WORD, 3'h1, 16'h8000);
    chk(operand_address_q, 32'hFFFF_8100);
  endtask
  task t_imm;
    @(posedge clk_sys);
    ext_word1 <= 16'h5678; implied_sel <= `IMPL_PC; opcode_word <= 16'h0003;
    ea(`MODE_QUICK, `SIZE_LONG, 3'h0, 16'h1234);
    chk(operand_value_q, 32'h0000_0008);
    ea(`MODE_IMMEDIATE, `SIZE_LONG, 3'h0, 16'h1234);
    chk(operand_value_q, 32'h1234_5678);
    ea(`MODE_ABS_LONG, `SIZE_LONG, 3'h0, 16'h1234);
    chk(operand_address_q, 32'h1234_5678);
    ea(`MODE_IMPLIED, `SIZE_LONG, 3'h0, 16'h0000);
    chk(operand_value_q, 32'h0000_0100);
  endtask
  task t_ops;
    op_count <= 6'h01;
    op(`OP_BIT_SET, 32'h0000_0005, 32'h0000_0001, 0);
    chk(op_result_q, 32'h0000_0021);
    op(`OP_BIT_CLEAR, 32'h0000_0000, 32'h0000_00FF, 0);
    chk(op_result_q, 32'h0000_00FE);
    op(`OP_DEC_ADD, 32'h0000_0019, 32'h0000_0028, 0);
    chk(op_result_q, 32'h0000_0047);
    op(`OP_ROTATE_LEFT_X, 32'h0000_0000, 32'h0000_0081, 0);
    chk(op_result_q, 32'h0000_0002);
    op(`OP_ROTATE_RIGHT_X, 32'h0000_0000, 32'h0000_0000, 0);
    chk(op_result_q, 32'h0000_0080);
    chk(status_word, 32'h0000_2711);
    op(`OP_TRAP, 32'h0000_0000, 32'h0000_0000, 0);
    chk(trap_vector_q, 32'h0000_0023);
    op(`OP_TRAP_OVF, 32'h0000_0000, 32'h0000_0000, 0);
    chk(trap_req_q, 0);
    op(`OP_MUL_U, 32'h0000_0010, 32'h0000_0020, 1);
    chk(op_result_q, 32'h0000_0200);
    op(`OP_DIV_U, 32'h0000_0007, 32'h0000_0064, 34);
    chk(op_result_q, 32'h0002_000E);
  endtask

  initial begin
    #200000;
    n_fail++;
    complete_run;
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    reset_n <= 1;
    t_direct;
    t_step;
    t_index;
    t_imm;
    t_ops;
    complete_run;
  end
endmodule // effective_address_generation_tb
